// [rtl/spi_ctl.sv]
`timescale 1ns/1ps
`include "spi_ctl_defines.svh"
// Contract
// [RULE_01] slave mode: overrun set when transfer ends while receive buffer unread
// [RULE_02] raising overrun also pulses the serial port interrupt request
// [RULE_03] overrun never self-clears; only a software write clears it
// [RULE_04] mode 00: three-wire, select line not routed to any pin
// [RULE_05] mode 01 (reset default): four-wire slave, select line is an input
// [RULE_06] mode 1x: single master, select line driven with field low bit
// [RULE_07] software write to transmit buffer clears transmit empty flag
// [RULE_08] transfer of buffer into shift register sets transmit empty flag
// [RULE_09] software writes transmit buffer only while the empty flag is set
// [RULE_10] enable bit zero disables the whole port
// [RULE_11] enable bit one activates shifting logic and pin drivers
module spi_ctl
  import spi_ctl_pkg::*;
#(
  parameter int XFER_BITS = `XFER_BITS
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // software control
  input wire logic port_enable_bit_i,
  input wire logic [1:0] slave_select_mode_field_i,
  input wire logic master_mode_i,
  input wire logic tx_write_i,
  input wire logic overrun_clear_i,
  input wire logic rx_read_i,
  // shift engine events
  input wire logic load_shift_i,
  input wire logic last_bit_i,
  // select pin
  input wire logic slave_select_line_i,
  output logic slave_select_line_o,
  output logic slave_select_line_oe_o,
  // status and requests
  output status_type status_o,
  output logic rx_full_o,
  output logic slave_selected_o,
  output logic shift_enable_o,
  output logic irq_req_o
);
  // every flag is a plain level; input pulses are one clock wide
  // and come from logic on this clock, so only the select pin is synchronised
  // overrun flag
  logic ovr_reg;
  logic ovr_next;
  // interrupt request pulse
  logic irq_reg;
  logic irq_next;
  // receive buffer occupancy
  logic rxf_reg;
  logic rxf_next;
  // transmit empty flag
  logic txe_reg;
  logic txe_next;
  // select pin drive registers
  logic sel_out_reg;
  logic sel_out_next;
  logic sel_oe_reg;
  logic sel_oe_next;
  // select pin level after synchroniser, and the slave selection it gives
  logic sel_level;
  logic sel_active;
  // events qualified by the enable
  logic port_on;
  logic slave_op;
  logic xfer_done;
  logic buf_moved;
  logic overrun_hit;
  // pin routing decided by the mode field
  sel_pin_type sel_pin;

  // select pin conditioning; idle level high so reset shows no select
  pin_sync u_sel_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(slave_select_line_i),
    .rst_val_i(1'b1),
    .level_o(sel_level)
  );

  // the enable gates every hardware event; a disabled port ignores its shifter
  assign port_on = port_enable_bit_i; // RULE_10 RULE_11
  // overrun is a slave-side condition only
  assign slave_op = port_on && !master_mode_i;
  // a transfer ends on its last shifted bit
  assign xfer_done = port_on && last_bit_i;
  // nothing moves to the shifter while the buffer is empty
  assign buf_moved = port_on && load_shift_i && !txe_reg;
  // a read in the same cycle frees the buffer in time, so no overrun
  assign overrun_hit = xfer_done && slave_op && rxf_reg && !rx_read_i;

  // pin routing per mode; a disabled port leaves the pin undriven
  always_comb begin
    sel_pin = '0;
    if (port_on) begin // RULE_11
      if (slave_select_mode_field_i[1]) begin
        sel_pin.routed = 1'b1;
        sel_pin.oe = 1'b1; // RULE_06
        sel_pin.out = slave_select_mode_field_i[0]; // RULE_06
      end else if (slave_select_mode_field_i == `SSM_FOUR_WIRE_SLAVE) begin
        sel_pin.routed = 1'b1; // RULE_05
      end else begin
        sel_pin.routed = 1'b0; // RULE_04
      end
    end
  end

  // select drive next values follow the routing
  always_comb begin
    sel_out_next = sel_pin.out;
    sel_oe_next = sel_pin.oe;
  end

  // select drive registers; released and parked high out of reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sel_out_reg <= `RST_SEL_OUT;
      sel_oe_reg <= 1'b0;
    end else begin
      sel_out_reg <= sel_out_next;
      sel_oe_reg <= sel_oe_next;
    end
  end

  // overrun flag; a new overrun beats a same-cycle software clear
  always_comb begin
    ovr_next = ovr_reg;
    if (overrun_clear_i) begin
      ovr_next = 1'b0; // RULE_03
    end
    if (overrun_hit) begin
      ovr_next = 1'b1; // RULE_01
    end
  end

  // overrun register; only software brings it back to zero
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ovr_reg <= `RST_OVERRUN;
    end else begin
      ovr_reg <= ovr_next;
    end
  end

  // interrupt request follows each raise of the overrun flag
  always_comb begin
    irq_next = overrun_hit; // RULE_02
  end

  // request register; one cycle wide so each overrun counts once
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // receive occupancy; a read and a new byte together leave it full
  always_comb begin
    rxf_next = rxf_reg;
    if (rx_read_i) begin
      rxf_next = 1'b0;
    end
    if (xfer_done && !overrun_hit) begin
      rxf_next = 1'b1;
    end
    if (!port_on) begin
      rxf_next = 1'b0; // RULE_10
    end
  end

  // receive occupancy register; a disabled port starts empty
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rxf_reg <= 1'b0;
    end else begin
      rxf_reg <= rxf_next;
    end
  end

  // transmit empty flag; the hardware set beats a same-cycle software write
  always_comb begin
    txe_next = txe_reg;
    if (tx_write_i) begin
      txe_next = 1'b0; // RULE_07
    end
    if (buf_moved) begin
      txe_next = 1'b1; // RULE_08
    end
  end

  // transmit empty register; the buffer starts free so software may write
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      txe_reg <= `RST_TX_EMPTY;
    end else begin
      txe_reg <= txe_next;
    end
  end

  // unrouted pin counts as always selected; a driven pin never selects us
  always_comb begin
    sel_active = 1'b0;
    if (!sel_pin.routed) begin
      sel_active = 1'b1; // RULE_04
    end else if (!sel_pin.oe) begin
      sel_active = !sel_level; // RULE_05
    end
  end

  // outputs; the select input lags the pin by three or four clocks
  assign slave_select_line_o = sel_out_reg;
  assign slave_select_line_oe_o = sel_oe_reg;
  assign status_o = '{receive_overrun_flag: ovr_reg, transmit_buffer_empty_flag: txe_reg};
  assign rx_full_o = rxf_reg;
  assign irq_req_o = irq_reg;
  assign shift_enable_o = port_on; // RULE_10
  assign slave_selected_o = slave_op && sel_active;
endmodule : spi_ctl

// [pkg/spi_ctl_defines.svh]
`ifndef SPI_CTL_DEFINES_SVH
`define SPI_CTL_DEFINES_SVH

// slave-select mode field encodings
`define SSM_THREE_WIRE 2'b00
`define SSM_FOUR_WIRE_SLAVE 2'b01
`define SSM_RESET 2'b01
// flag and pin reset values
`define RST_OVERRUN 1'b0
`define RST_TX_EMPTY 1'b1
`define RST_SEL_OUT 1'b1
// bit positions of the status/control byte
`define BIT_OVERRUN 4
`define BIT_SSM_HI 3
`define BIT_SSM_LO 2
`define BIT_TX_EMPTY 1
`define BIT_ENABLE 0
// transfer length in bits
`define XFER_BITS 8

`endif

// [pkg/spi_ctl_pkg.sv]
package spi_ctl_pkg;

  // select line pin control
  typedef struct packed {
    logic out;
    logic oe;
    logic routed;
  } sel_pin_type;

  // status snapshot
  typedef struct packed {
    logic receive_overrun_flag;
    logic transmit_buffer_empty_flag;
  } status_type;

endpackage : spi_ctl_pkg

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once stages two and three agree
module pin_sync (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // pin in, filtered level out
  input wire logic pin_i,
  input wire logic rst_val_i,
  output logic level_o
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic level_reg;
  logic level_next;

  // shift in; first stage read only by the second
  always_comb begin
    sync_next = {sync_reg[1:0], pin_i};
    level_next = (sync_reg[2] == sync_reg[1]) ? sync_reg[2] : level_reg;
  end

  // reset value tied to constant high in use, keeps idle select inactive
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sync_reg <= {3{rst_val_i}};
      level_reg <= rst_val_i;
    end else begin
      sync_reg <= sync_next;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;
endmodule : pin_sync

// [test/spi_ctl_checker.sv]
`timescale 1ns/1ps
module spi_ctl_checker
  import spi_ctl_pkg::*;
(
  // watched ports
  input logic clk_sys_i, sys_rst_i, port_enable_bit_i, master_mode_i, tx_write_i,
  input logic overrun_clear_i, rx_read_i, load_shift_i, last_bit_i, irq_req_o,
  input logic [1:0] slave_select_mode_field_i,
  input logic slave_select_line_o, slave_select_line_oe_o, rx_full_o, shift_enable_o,
  input status_type status_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // slave transfer ends while the receive buffer is still unread
  sequence ovr_cause;
    port_enable_bit_i && !master_mode_i && rx_full_o && last_bit_i && !rx_read_i;
  endsequence
  chk_ovr_set: assert property (ovr_cause |=> status_o[1]) else $error("ovr");
  chk_ovr_irq: assert property ($rose(status_o[1]) |-> irq_req_o ##1 !irq_req_o)
    else $error("irq");
  chk_ovr_hold: assert property (status_o[1] && !overrun_clear_i |=> status_o[1])
    else $error("hold");
  chk_sel_none: assert property (slave_select_mode_field_i == 2'h0 |=>
    !slave_select_line_oe_o) else $error("sel0");
  chk_sel_in: assert property (slave_select_mode_field_i == 2'h1 |=>
    !slave_select_line_oe_o) else $error("sel1");
  chk_sel_out: assert property (slave_select_mode_field_i[1] && port_enable_bit_i |=>
    slave_select_line_oe_o && slave_select_line_o == $past(slave_select_mode_field_i[0]))
    else $error("sel2");
  chk_tx_clr: assert property (tx_write_i && !load_shift_i |=> !status_o[0])
    else $error("txc");
  chk_tx_set: assert property (load_shift_i && port_enable_bit_i |=> status_o[0])
    else $error("txs");
  chk_port_off: assert property (!port_enable_bit_i |-> !shift_enable_o ##1
    !slave_select_line_oe_o) else $error("off");
  chk_port_on: assert property (port_enable_bit_i |-> shift_enable_o) else $error("on");
endmodule : spi_ctl_checker

bind spi_ctl spi_ctl_checker i_spi_ctl_checker (.*);

// [test/spi_far_master.sv]
`timescale 1ns/1ps
// far master: select low for eight bit times, then marks the last bit
module spi_far_master (
  // clock and frame request
  input wire logic clk_sys_i,
  input wire logic start_i,
  // select line, pulled up when released
  output logic sel_n_o,
  output logic last_o
);
  logic [3:0] cnt_reg = 4'h0;
  // count down; frames are never cut short
  always @(posedge clk_sys_i) begin
    cnt_reg <= start_i ? 4'h8 : cnt_reg - {3'h0, cnt_reg != 4'h0};
    last_o <= cnt_reg == 4'h1;
  end
  assign sel_n_o = cnt_reg == 4'h0;
endmodule : spi_far_master

// [test/spi_ctl_test.sv]
`timescale 1ns/1ps
module spi_ctl_test;
  import spi_ctl_pkg::*;
  // pulses: 0 tx write, 1 clear, 2 rx read, 3 load, 4 frame start
  logic clk_sys_i = 0, sys_rst_i = 1, en = 0, mst = 0;
  logic [4:0] pul = 5'h0;
  logic [1:0] mode = 2'h1;
  logic so, oe, fsel, flast, rxf, ssel, shen, irq;
  status_type st;
  int fails = 0, check_count = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  // device drive wins, else the far master
  wire pin = oe ? so : fsel;
  spi_far_master i_spi_far_master (.clk_sys_i, .start_i(pul[4]), .sel_n_o(fsel), .last_o(flast));
  spi_ctl i_spi_ctl (.clk_sys_i, .sys_rst_i, .port_enable_bit_i(en),
    .slave_select_mode_field_i(mode), .master_mode_i(mst), .tx_write_i(pul[0]),
    .overrun_clear_i(pul[1]), .rx_read_i(pul[2]), .load_shift_i(pul[3]), .last_bit_i(flast),
    .slave_select_line_i(pin), .slave_select_line_o(so), .slave_select_line_oe_o(oe),
    .status_o(st), .rx_full_o(rxf), .slave_selected_o(ssel), .shift_enable_o(shen),
    .irq_req_o(irq));
  task chk(input logic s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("Error %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task hit(input int b);
    @(posedge clk_sys_i) pul[b] <= 1'b1;
    @(posedge clk_sys_i) pul[b] <= 1'b0;
    #1;
  endtask : hit
  // one far-side frame, bounded wait for its last bit
  task frame;
    hit(4);
    repeat (20) if (!flast) @(posedge clk_sys_i) #1;
    if (!flast) begin
      fails++;
      test_done;
    end
    chk(ssel, en && !mode[1] && !mst);
    @(posedge clk_sys_i) #1;
  endtask : frame
  task t_tx;
    hit(0);
    chk(st[0], 1'b0);
    hit(3);
    chk(st[0], 1'b1);
    $display("tx flag done");
  endtask : t_tx
  task t_ovr;
    frame;
    chk(rxf, 1'b1);
    frame;
    chk(st[1], 1'b1);
    chk(irq, 1'b1);
    hit(2);
    chk(st[1], 1'b1);
    hit(1);
    chk(st[1], 1'b0);
    $display("overrun done");
  endtask : t_ovr
  task t_mst;
    @(posedge clk_sys_i) mst <= 1'b1;
    frame;
    frame;
    chk(rxf, 1'b1);
    chk(st[1], 1'b0);
    chk(irq, 1'b0);
    hit(2);
    @(posedge clk_sys_i) mst <= 1'b0;
    $display("master mode done");
  endtask : t_mst
  task t_sel;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys_i) mode <= m[1:0];
      repeat (2) @(posedge clk_sys_i);
      #1 chk(oe, m[1]);
      if (m[1]) chk(pin, m[0]);
      chk(ssel, m == 0);
    end
    $display("select modes done");
  endtask : t_sel
  task t_dis;
    frame;
    chk(rxf, 1'b1);
    @(posedge clk_sys_i) en <= 1'b0;
    @(posedge clk_sys_i) #1 chk(shen, 1'b0);
    chk(oe, 1'b0);
    chk(rxf, 1'b0);
    frame;
    chk(rxf, 1'b0);
    @(posedge clk_sys_i) en <= 1'b1;
    @(posedge clk_sys_i) #1 chk(oe, 1'b1);
    chk(shen, 1'b1);
    $display("enable done");
  endtask : t_dis
  initial begin
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    en <= 1'b1;
    t_tx;
    t_ovr;
    t_mst;
    t_sel;
    t_dis;
    test_done;
  end
endmodule : spi_ctl_test
